/* File: shared/psp_pkg.sv */
package psp_pkg;
	// -----------------------------------------------------------------
	// mode, increment and irq field encodings
	// -----------------------------------------------------------------
	localparam logic [1:0] PSP_MODE_LEGACY = 2'h0;
	localparam logic [1:0] PSP_MODE_ADDR = 2'h1;
	localparam logic [1:0] PSP_INC_BUFFERED = 2'h3;
	localparam logic [1:0] PSP_IRQ_EVERY = 2'h1;
	localparam logic [1:0] PSP_IRQ_LAST = 2'h3;
	// -----------------------------------------------------------------
	// buffer layout
	// -----------------------------------------------------------------
	localparam int PSP_SLOTS = 4;
	localparam logic [1:0] PSP_SLOT_FIRST = 2'h0;
	localparam logic [1:0] PSP_SLOT_LAST = 2'h3;
	localparam logic [3:0] PSP_OUT_EMPTY_RST = 4'hf;
	localparam logic [3:0] PSP_IN_FULL_RST = 4'h0;
	localparam int PSP_FIFO_DEPTH = 4;
endpackage : psp_pkg

/* File: hw/psp_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module psp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	// fill side
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	// drain side
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
			$error("psp_fifo: depth must be a power of two of at least 2");
		end
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] rd_ptr_reg;
	logic full;
	logic empty;
	assign empty = (wr_ptr_reg == rd_ptr_reg);
	assign full = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) && (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
	assign o_ready = !full;
	assign o_valid = !empty;
	assign o_data = mem[rd_ptr_reg[AW-1:0]];
	always_ff @(posedge i_sys_clk) begin
		if (i_valid && !full) begin
			mem[wr_ptr_reg[AW-1:0]] <= i_data;
		end
	end
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			wr_ptr_reg <= '0;
		end else if (i_valid && !full) begin
			wr_ptr_reg <= wr_ptr_reg + 1'b1;
		end
	end
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			rd_ptr_reg <= '0;
		end else if (i_ready && !empty) begin
			rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end
endmodule : psp_fifo
`default_nettype wire

/* File: hw/psp_slave.sv */
// Notes on behaviour
// - port answers only when enabled and mode is legacy or addressable.
// - mode 00 is a single-byte slave driven by host strobes.
// - read, write and select polarities are each selectable.
// - legacy write captures byte 0; input full set at write start, irq at write end.
// - legacy read drives byte 0 and sets all-outputs-empty.
// - software output write after host read leaves all-outputs-empty set.
// - select or read going inactive releases data pins and sets irq.
// - increment field 11 in legacy mode enables four-slot buffering.
// - slots 0..3 run from low byte of first word to high of second.
// - buffered reads send slots in order via a read pointer.
// - each output slot has an empty bit, set once driven.
// - buffered read of empty slot sets output underrun.
// - all-outputs-empty when all four slot empty bits set.
// - buffered writes fill slots in order via a write pointer.
// - slot full bit set by host write, cleared by software read.
// - host write into full slot sets input overrun, byte lost.
// - all-inputs-full when all four slot full bits set.
// - irq field 01 every strobe; 11 only on slot 3 access.
// - mode 01 is addressable, two address inputs pick the slot.
// - address 00..11 picks slot 0..3 for both directions.
// - addressable read drives slot, sets empty; empty read underruns.
// - addressable write into full slot flags error and drops byte.
// - overrun and underrun stay set until software clears them.
// - software read of an input slot clears its full bit.
`timescale 1ns/10ps
`default_nettype none
module psp_slave
	import psp_pkg::*;
#(
	parameter int DATA_W = 8,
	parameter int FIFO_DEPTH = PSP_FIFO_DEPTH
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	// configuration
	input wire logic i_port_module_on,
	input wire logic [1:0] i_port_mode,
	input wire logic [1:0] i_buffered_select_field,
	input wire logic [1:0] i_irq_condition_field,
	input wire logic i_read_pol_high,
	input wire logic i_write_pol_high,
	input wire logic i_select_pol_high,
	// host pins
	input wire logic [DATA_W-1:0] i_slave_data_bus,
	output logic [DATA_W-1:0] o_slave_data_bus,
	output logic o_slave_data_bus_oe,
	input wire logic i_host_read_strobe,
	input wire logic i_host_write_strobe,
	input wire logic i_slave_select_in,
	input wire logic [1:0] i_buffer_select_in,
	// software output side: load one output slot
	input wire logic i_out_load,
	input wire logic [1:0] i_out_slot,
	input wire logic [DATA_W-1:0] i_out_data,
	// software input side: stream of received bytes
	output logic o_in_valid,
	input wire logic i_in_ready,
	output logic [DATA_W-1:0] o_in_data,
	output logic [1:0] o_in_slot,
	// status
	input wire logic i_clear_errors,
	output logic [3:0] o_input_slot_full,
	output logic [3:0] o_output_slot_empty,
	output logic o_all_inputs_full,
	output logic o_all_outputs_empty,
	output logic o_input_overrun,
	output logic o_output_underrun,
	output logic o_port_irq_flag
);
	initial begin
		if (DATA_W != 8 || FIFO_DEPTH < 2) begin
			$error("psp_slave: byte-wide bus and fifo depth of at least 2 required");
		end
	end
	// -----------------------------------------------------------------
	// mode decode and strobe polarity
	// -----------------------------------------------------------------
	logic active;
	logic addr_mode;
	logic buf_mode;
	logic sel;
	logic rd;
	logic wr;
	assign active = i_port_module_on
		&& (i_port_mode == PSP_MODE_LEGACY || i_port_mode == PSP_MODE_ADDR);
	assign addr_mode = active && i_port_mode == PSP_MODE_ADDR;
	assign buf_mode = active && i_port_mode == PSP_MODE_LEGACY
		&& i_buffered_select_field == PSP_INC_BUFFERED;
	assign sel = i_slave_select_in ~^ i_select_pol_high;
	assign rd = i_host_read_strobe ~^ i_read_pol_high;
	assign wr = i_host_write_strobe ~^ i_write_pol_high;
	logic rd_act;
	logic wr_act;
	assign rd_act = active && sel && rd;
	assign wr_act = active && sel && wr;
	logic rd_act_reg;
	logic wr_act_reg;
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			rd_act_reg <= 1'b0;
			wr_act_reg <= 1'b0;
		end else begin
			rd_act_reg <= rd_act;
			wr_act_reg <= wr_act;
		end
	end
	logic rd_start;
	logic rd_end;
	logic wr_start;
	logic wr_end;
	assign rd_start = rd_act && !rd_act_reg;
	assign rd_end = !rd_act && rd_act_reg;
	assign wr_start = wr_act && !wr_act_reg;
	assign wr_end = !wr_act && wr_act_reg;
	// -----------------------------------------------------------------
	// slot selection and pointers
	// -----------------------------------------------------------------
	logic [1:0] rd_ptr_reg;
	logic [1:0] wr_ptr_reg;
	logic [1:0] rd_slot;
	logic [1:0] wr_slot;
	logic [1:0] rd_slot_reg;
	logic [1:0] wr_slot_reg;
	always_comb begin
		if (addr_mode) begin
			rd_slot = i_buffer_select_in;
			wr_slot = i_buffer_select_in;
		end else if (buf_mode) begin
			rd_slot = rd_ptr_reg;
			wr_slot = wr_ptr_reg;
		end else begin
			rd_slot = PSP_SLOT_FIRST;
			wr_slot = PSP_SLOT_FIRST;
		end
	end
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn || !i_port_module_on) begin
			rd_ptr_reg <= PSP_SLOT_FIRST;
		end else if (!buf_mode) begin
			rd_ptr_reg <= PSP_SLOT_FIRST;
		end else if (rd_start) begin
			rd_ptr_reg <= rd_ptr_reg + 2'h1;
		end
	end
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn || !i_port_module_on) begin
			wr_ptr_reg <= PSP_SLOT_FIRST;
		end else if (!buf_mode) begin
			wr_ptr_reg <= PSP_SLOT_FIRST;
		end else if (wr_start) begin
			wr_ptr_reg <= wr_ptr_reg + 2'h1;
		end
	end
	// slot held from strobe start so the end-of-strobe interrupt knows it
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			rd_slot_reg <= PSP_SLOT_FIRST;
			wr_slot_reg <= PSP_SLOT_FIRST;
		end else begin
			if (rd_start) begin
				rd_slot_reg <= rd_slot;
			end
			if (wr_start) begin
				wr_slot_reg <= wr_slot;
			end
		end
	end
	// -----------------------------------------------------------------
	// slot state: software loads and host reads output slots; host writes fill input slots
	// -----------------------------------------------------------------
	logic [DATA_W-1:0] out_mem [PSP_SLOTS];
	logic [3:0] out_empty_reg;
	logic [3:0] in_full_reg;
	logic [DATA_W-1:0] bus_out_reg;
	logic bus_oe_reg;
	// a slot is marked full only when its byte really enters the fifo
	logic push;
	genvar g;
	generate
		for (g = 0; g < PSP_SLOTS; g++) begin : g_slot
			always_ff @(posedge i_sys_clk) begin
				if (i_out_load && i_out_slot == 2'(g)) begin
					out_mem[g] <= i_out_data;
				end
			end
			// host read marks empty; in legacy mode a software load must not clear it
			always_ff @(posedge i_sys_clk) begin
				if (!i_rstn || (i_port_module_on && !active)) begin
					out_empty_reg[g] <= PSP_OUT_EMPTY_RST[g];
				end else if (rd_start && rd_slot == 2'(g)) begin
					out_empty_reg[g] <= 1'b1;
				end else if (i_out_load && i_out_slot == 2'(g) && (buf_mode || addr_mode)) begin
					out_empty_reg[g] <= 1'b0;
				end
			end
			// stored byte sets full; fifo take clears it, and the set wins
			always_ff @(posedge i_sys_clk) begin
				if (!i_rstn || (i_port_module_on && !active)) begin
					in_full_reg[g] <= PSP_IN_FULL_RST[g];
				end else if (push && wr_slot == 2'(g)) begin
					in_full_reg[g] <= 1'b1;
				end else if (o_in_valid && i_in_ready && o_in_slot == 2'(g)) begin
					in_full_reg[g] <= 1'b0;
				end
			end
		end
	endgenerate
	// data pins driven only while the read strobe is active
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			bus_out_reg <= '0;
			bus_oe_reg <= 1'b0;
		end else if (rd_act) begin
			bus_out_reg <= out_mem[rd_act_reg ? rd_slot_reg : rd_slot];
			bus_oe_reg <= 1'b1;
		end else begin
			bus_oe_reg <= 1'b0;
		end
	end
	assign o_slave_data_bus = bus_out_reg;
	assign o_slave_data_bus_oe = bus_oe_reg && rd_act;
	// -----------------------------------------------------------------
	// input path: bytes go to software through a small fifo
	// -----------------------------------------------------------------
	logic fifo_ready;
	logic [DATA_W+1:0] fifo_out;
	// a full slot or full fifo drops the byte; fifo back-pressure is an overrun, or an underrun in addressable mode
	assign push = wr_start && !in_full_reg[wr_slot] && fifo_ready;
	psp_fifo #(
		.WIDTH(DATA_W + 2),
		.DEPTH(FIFO_DEPTH)
	) u_in_fifo (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn && !(i_port_module_on && !active)),
		.i_valid(push),
		.o_ready(fifo_ready),
		.i_data({wr_slot, i_slave_data_bus}),
		.o_valid(o_in_valid),
		.i_ready(i_in_ready),
		.o_data(fifo_out)
	);
	assign o_in_data = fifo_out[DATA_W-1:0];
	assign o_in_slot = fifo_out[DATA_W+1:DATA_W];
	// -----------------------------------------------------------------
	// error flags and interrupt
	// -----------------------------------------------------------------
	logic overrun_reg;
	logic underrun_reg;
	logic irq_reg;
	logic write_err;
	logic read_err;
	assign write_err = wr_start && (in_full_reg[wr_slot] || !fifo_ready);
	assign read_err = rd_start && (buf_mode || addr_mode) && out_empty_reg[rd_slot];
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn || (i_port_module_on && !active)) begin
			overrun_reg <= 1'b0;
		end else if (write_err && !addr_mode) begin
			overrun_reg <= 1'b1;
		end else if (i_clear_errors) begin
			overrun_reg <= 1'b0;
		end
	end
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn || (i_port_module_on && !active)) begin
			underrun_reg <= 1'b0;
		end else if (read_err || (write_err && addr_mode)) begin
			underrun_reg <= 1'b1;
		end else if (i_clear_errors) begin
			underrun_reg <= 1'b0;
		end
	end
	logic irq_event;
	always_comb begin
		irq_event = 1'b0;
		if (buf_mode || addr_mode) begin
			case (i_irq_condition_field)
				PSP_IRQ_EVERY: irq_event = rd_end || wr_end;
				PSP_IRQ_LAST: irq_event = (rd_end && rd_slot_reg == PSP_SLOT_LAST)
					|| (wr_end && wr_slot_reg == PSP_SLOT_LAST);
				default: irq_event = 1'b0;
			endcase
		end else begin
			irq_event = rd_end || wr_end;
		end
	end
	// flag is a one-cycle pulse per strobe end that meets the irq condition
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= irq_event;
		end
	end
	assign o_port_irq_flag = irq_reg;
	assign o_input_slot_full = in_full_reg;
	assign o_output_slot_empty = out_empty_reg;
	assign o_all_inputs_full = buf_mode || addr_mode ? &in_full_reg : in_full_reg[0];
	assign o_all_outputs_empty = buf_mode || addr_mode ? &out_empty_reg : out_empty_reg[0];
	assign o_input_overrun = overrun_reg;
	assign o_output_underrun = underrun_reg;
	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	AST_NO_ACCESS_OFF: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		!active |=> !bus_oe_reg) else $error("data bus driven while port inactive");
	AST_WR_SETS_FULL: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(wr_start && !addr_mode && !buf_mode && active) |=> o_input_slot_full[0])
		else $error("write did not mark slot 0 full");
	AST_RD_SETS_EMPTY: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(rd_start && rd_slot == PSP_SLOT_LAST) |=> o_output_slot_empty[3])
		else $error("read did not mark slot 3 empty");
	AST_UNDERRUN: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(read_err && active) |=> o_output_underrun) else $error("underrun not flagged");
	AST_OVERRUN: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(buf_mode && wr_start && in_full_reg[wr_slot]) |-> !push ##1 o_input_overrun)
		else $error("overrun not flagged or byte kept");
	AST_STICKY: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(o_input_overrun && !i_clear_errors && active) |=> o_input_overrun)
		else $error("overrun flag dropped without clear");
	AST_WRAP: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(buf_mode && wr_start && wr_ptr_reg == PSP_SLOT_LAST) |=> (wr_ptr_reg == PSP_SLOT_FIRST))
		else $error("write pointer failed to wrap");
	AST_IRQ_END: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(active && !buf_mode && !addr_mode && $fell(rd_act)) |-> ##1 o_port_irq_flag)
		else $error("no interrupt after read end");
	// -----------------------------------------------------------------
	// checks: pointers, status and interrupt
	// -----------------------------------------------------------------
	AST_RD_ADVANCE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(buf_mode && rd_start) |=> (rd_ptr_reg == 2'($past(rd_ptr_reg) + 2'h1)))
		else $error("read pointer did not advance");
	AST_WR_ADVANCE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(buf_mode && wr_start) |=> (wr_ptr_reg == 2'($past(wr_ptr_reg) + 2'h1)))
		else $error("write pointer did not advance");
	AST_OE_RELEASE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		$fell(rd_act) |=> !o_slave_data_bus_oe)
		else $error("data pins still driven after read end");
	AST_LEGACY_EMPTY: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(active && !buf_mode && !addr_mode && o_output_slot_empty[0]) |=> o_output_slot_empty[0])
		else $error("legacy empty flag cleared");
	AST_ALL_EMPTY: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(buf_mode || addr_mode) |-> (o_all_outputs_empty == &o_output_slot_empty))
		else $error("all-outputs-empty disagrees with slot bits");
	AST_ALL_FULL: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(buf_mode || addr_mode) |-> (o_all_inputs_full == &o_input_slot_full))
		else $error("all-inputs-full disagrees with slot bits");
	AST_ADDR_WR_ERR: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(addr_mode && wr_start && in_full_reg[wr_slot]) |-> !push ##1 o_output_underrun)
		else $error("addressable write to full slot not refused");
	AST_UNDERRUN_STICKY: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(o_output_underrun && !i_clear_errors && active) |=> o_output_underrun)
		else $error("underrun flag dropped without clear");
	AST_WR_SETS_SLOT: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		push |=> o_input_slot_full[$past(wr_slot)])
		else $error("stored byte did not mark its slot full");
	AST_TAKE_CLEARS: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(o_in_valid && i_in_ready && !(push && wr_slot == o_in_slot))
			|=> !o_input_slot_full[$past(o_in_slot)])
		else $error("software take did not clear slot full");
	AST_IRQ_EVERY: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		((buf_mode || addr_mode) && i_irq_condition_field == PSP_IRQ_EVERY && wr_end)
			|=> o_port_irq_flag)
		else $error("no interrupt after write end");
	AST_IRQ_LAST: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(buf_mode && i_irq_condition_field == PSP_IRQ_LAST && rd_end && !wr_end
			&& rd_slot_reg != PSP_SLOT_LAST) |=> !o_port_irq_flag)
		else $error("interrupt on a read before the last slot");
	AST_INACTIVE_IDLE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		(i_port_module_on && !active) |=> (o_input_slot_full == PSP_IN_FULL_RST
			&& o_output_slot_empty == PSP_OUT_EMPTY_RST && !o_in_valid))
		else $error("slot state kept while port inactive");
endmodule : psp_slave
`default_nettype wire

/* File: tb/psp_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module psp_host_model (
	// clock
	input wire logic i_sys_clk,
	// strobe polarity, 1 = active high
	input wire logic i_rd_hi,
	input wire logic i_wr_hi,
	input wire logic i_cs_hi,
	// host pins
	input wire logic [7:0] i_bus,
	output logic [7:0] o_bus,
	output logic o_drive,
	output logic o_rd,
	output logic o_wr,
	output logic o_cs,
	output logic [1:0] o_addr
);
	logic rd_act = 1'b0;
	logic wr_act = 1'b0;
	logic cs_act = 1'b0;
	initial begin
		o_bus = 8'h00;
		o_drive = 1'b0;
		o_addr = 2'h0;
	end
	assign o_rd = rd_act ~^ i_rd_hi;
	assign o_wr = wr_act ~^ i_wr_hi;
	assign o_cs = cs_act ~^ i_cs_hi;
	// -----------------------------------------------------------------
	// one host access: strobe held three edges, then one idle cycle
	// -----------------------------------------------------------------
	task automatic access(input logic wr, input logic [1:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge i_sys_clk);
		cs_act <= 1'b1;
		rd_act <= !wr;
		wr_act <= wr;
		o_addr <= a;
		o_bus <= d;
		o_drive <= wr;
		repeat (2) @(posedge i_sys_clk);
		#1 q = i_bus;
		@(posedge i_sys_clk);
		cs_act <= 1'b0;
		rd_act <= 1'b0;
		wr_act <= 1'b0;
		o_drive <= 1'b0;
		// released lines float: show the inverse, never the held value
		o_bus <= ~q;
		o_addr <= ~a;
		@(posedge i_sys_clk);
	endtask : access
endmodule : psp_host_model
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
	import psp_pkg::*;
	logic i_sys_clk, i_rstn, on, rph, wph, cph, ld, rdy, clr;
	logic [1:0] mode, inc, irqf, ls;
	logic [7:0] ldd, q, bus;
	logic [7:0] dbus, hbus;
	logic oe, hdrv, hrd, hwr, hcs, ival, aif, aoe, iov, oun, irq;
	logic [1:0] ha, islot;
	logic [7:0] idata;
	logic [3:0] fullv, emptyv;
	int err_total = 0;
	int compares = 0;
	int irq_cnt = 0;
	int irq0, i, n;
	assign bus = oe ? dbus : hbus;
	always @(posedge i_sys_clk) if (irq === 1'b1) irq_cnt++;
	always @(negedge i_sys_clk) if (hdrv === 1'b1) check("bus clash", {7'h0, oe}, 8'h00);
	initial begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end
	psp_host_model u_psp_host_model (.i_sys_clk(i_sys_clk), .i_rd_hi(rph), .i_wr_hi(wph),
		.i_cs_hi(cph), .i_bus(bus), .o_bus(hbus), .o_drive(hdrv), .o_rd(hrd), .o_wr(hwr),
		.o_cs(hcs), .o_addr(ha));
	psp_slave u_psp_slave (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_port_module_on(on),
		.i_port_mode(mode), .i_buffered_select_field(inc), .i_irq_condition_field(irqf),
		.i_read_pol_high(rph), .i_write_pol_high(wph), .i_select_pol_high(cph),
		.i_slave_data_bus(bus), .o_slave_data_bus(dbus), .o_slave_data_bus_oe(oe),
		.i_host_read_strobe(hrd), .i_host_write_strobe(hwr), .i_slave_select_in(hcs),
		.i_buffer_select_in(ha), .i_out_load(ld), .i_out_slot(ls), .i_out_data(ldd),
		.o_in_valid(ival), .i_in_ready(rdy), .o_in_data(idata), .o_in_slot(islot),
		.i_clear_errors(clr), .o_input_slot_full(fullv), .o_output_slot_empty(emptyv),
		.o_all_inputs_full(aif), .o_all_outputs_empty(aoe), .o_input_overrun(iov),
		.o_output_underrun(oun), .o_port_irq_flag(irq));
	// -----------------------------------------------------------------
	// tasks
	// -----------------------------------------------------------------
	task automatic end_of_test;
		$display("checks %0d errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic settle;
		repeat (3) @(posedge i_sys_clk);
		#1;
	endtask : settle
	task automatic cfg(input logic [1:0] m, input logic [1:0] c, input logic [1:0] r,
		input logic [2:0] p);
		// passing through an inactive mode resets slot state between tests
		@(posedge i_sys_clk);
		mode <= 2'h2;
		clr <= 1'b1;
		{rph, wph, cph} <= p;
		@(posedge i_sys_clk);
		mode <= m;
		inc <= c;
		irqf <= r;
		clr <= 1'b0;
		settle();
	endtask : cfg
	task automatic hw(input logic [1:0] a, input logic [7:0] d);
		u_psp_host_model.access(1'b1, a, d, q);
	endtask : hw
	task automatic hr(input logic [1:0] a);
		u_psp_host_model.access(1'b0, a, 8'h00, q);
	endtask : hr
	task automatic load(input logic [1:0] s, input logic [7:0] d);
		@(posedge i_sys_clk);
		ld <= 1'b1;
		ls <= s;
		ldd <= d;
		@(posedge i_sys_clk);
		ld <= 1'b0;
	endtask : load
	task automatic pulse_clr;
		@(posedge i_sys_clk);
		clr <= 1'b1;
		@(posedge i_sys_clk);
		clr <= 1'b0;
		settle();
	endtask : pulse_clr
	task automatic pop(input logic [7:0] d, input logic [1:0] s);
		#1;
		n = 0;
		while (ival !== 1'b1 && n < 20) begin
			@(posedge i_sys_clk);
			#1;
			n++;
		end
		if (ival !== 1'b1) begin
			err_total++;
			end_of_test();
		end
		check("in data", idata, d);
		check("in slot", {6'h0, islot}, {6'h0, s});
		@(posedge i_sys_clk);
		rdy <= 1'b1;
		@(posedge i_sys_clk);
		rdy <= 1'b0;
	endtask : pop
	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial begin
		{i_rstn, ld, rdy, clr, mode, inc, irqf, ls, ldd} = '0;
		{on, rph, wph, cph} = 4'hf;
		repeat (10) @(posedge i_sys_clk);
		i_rstn <= 1'b1;
		settle();
		check("out empty", {4'h0, emptyv}, {4'h0, PSP_OUT_EMPTY_RST});
		check("flags", {2'h0, fullv, iov, oun}, 8'h00);
		// legacy mode with active-low strobes
		cfg(PSP_MODE_LEGACY, 2'h0, 2'h0, 3'h0);
		irq0 = irq_cnt;
		hw(2'h0, 8'h5a);
		settle();
		check("in full", {4'h0, fullv}, 8'h01);
		check("all in full", {7'h0, aif}, 8'h01);
		check("irq count", 8'(irq_cnt - irq0), 8'h01);
		pop(8'h5a, 2'h0);
		settle();
		check("in full", {4'h0, fullv}, 8'h00);
		load(2'h0, 8'ha5);
		hr(2'h0);
		check("read data", q, 8'ha5);
		load(2'h0, 8'h3c);
		settle();
		check("all out empty", {7'h0, aoe}, 8'h01);
		check("bus oe", {7'h0, oe}, 8'h00);
		check("irq count", 8'(irq_cnt - irq0), 8'h02);
		// buffered mode, irq on slot 3 only
		cfg(PSP_MODE_LEGACY, PSP_INC_BUFFERED, PSP_IRQ_LAST, 3'h7);
		for (i = 0; i < 4; i++) load(2'(i), 8'h10 + 8'(i));
		settle();
		check("out empty", {4'h0, emptyv}, 8'h00);
		check("all out empty", {7'h0, aoe}, 8'h00);
		irq0 = irq_cnt;
		for (i = 0; i < 4; i++) begin
			hr(2'h0);
			check("read data", q, 8'h10 + 8'(i));
		end
		settle();
		check("out empty", {4'h0, emptyv}, 8'h0f);
		check("all out empty", {7'h0, aoe}, 8'h01);
		check("irq count", 8'(irq_cnt - irq0), 8'h01);
		load(2'h0, 8'h77);
		hr(2'h0);
		check("read data", q, 8'h77);
		hr(2'h0);
		load(2'h2, 8'h01);
		settle();
		check("underrun", {7'h0, oun}, 8'h01);
		pulse_clr();
		check("underrun", {7'h0, oun}, 8'h00);
		// fill the input slots and the fifo while software stalls
		for (i = 0; i < 4; i++) hw(2'h0, 8'h20 + 8'(i));
		settle();
		check("in full", {4'h0, fullv}, 8'h0f);
		check("all in full", {7'h0, aif}, 8'h01);
		hw(2'h0, 8'hee);
		settle();
		check("overrun", {7'h0, iov}, 8'h01);
		for (i = 0; i < 4; i++) pop(8'h20 + 8'(i), 2'(i));
		settle();
		check("in full", {4'h0, fullv}, 8'h00);
		check("overrun", {7'h0, iov}, 8'h01);
		pulse_clr();
		check("overrun", {7'h0, iov}, 8'h00);
		// addressable mode, irq on every strobe
		cfg(PSP_MODE_ADDR, 2'h0, PSP_IRQ_EVERY, 3'h5);
		irq0 = irq_cnt;
		hw(2'h2, 8'h42);
		settle();
		check("in full", {4'h0, fullv}, 8'h04);
		hw(2'h2, 8'h99);
		settle();
		check("underrun", {7'h0, oun}, 8'h01);
		pop(8'h42, 2'h2);
		pulse_clr();
		load(2'h3, 8'h33);
		hr(2'h3);
		check("read data", q, 8'h33);
		settle();
		check("out empty", {4'h0, emptyv}, 8'h0f);
		hr(2'h3);
		settle();
		check("underrun", {7'h0, oun}, 8'h01);
		check("irq count", 8'(irq_cnt - irq0), 8'h04);
		// inactive mode ignores the host
		cfg(2'h2, 2'h0, 2'h0, 3'h7);
		hw(2'h0, 8'h11);
		settle();
		check("in full", {3'h0, ival, fullv}, 8'h00);
		end_of_test();
	end
endmodule : tb
`default_nettype wire
